/* File: verilog/asrf_regs.svh */
// register indices, field positions and timing counts of the serial rate and flag block
// assumes a bus with word-aligned registers: byte address is four times the index
`ifndef ASRF_REGS_SVH
`define ASRF_REGS_SVH
`define ASRF_IDX_BAUD 6'h2b
`define ASRF_IDX_CTRL 6'h2d
`define ASRF_IDX_STAT 6'h2e
`define ASRF_IDX_DATA 6'h2f
`define ASRF_BAUD_CLR 7
`define ASRF_BAUD_PRE 4
`define ASRF_BAUD_CHK 3
`define ASRF_C_TIE 7
`define ASRF_C_TX_DONE_IRQ_ENABLE 6
`define ASRF_C_RIE 5
`define ASRF_C_LINE_QUIET_IRQ_ENABLE 4
`define ASRF_C_TE 3
`define ASRF_C_RE 2
`define ASRF_C_RWU 1
`define ASRF_C_SBK 0
`define ASRF_F_TX_HOLDING_EMPTY_FLAG 6
`define ASRF_F_TC 5
`define ASRF_F_RX_HOLDING_FULL_FLAG 4
`define ASRF_F_IDLE 3
`define ASRF_F_OR 2
`define ASRF_F_NF 1
`define ASRF_F_FE 0
`define ASRF_FLAG_RST 7'h60
`define ASRF_TX_MASK 7'h60
`define ASRF_RX_MASK 7'h1f
`define ASRF_PRE_T0 4'h0
`define ASRF_PRE_T1 4'h2
`define ASRF_PRE_T2 4'h3
`define ASRF_PRE_T3 4'hc
`define ASRF_RATE_ALL 7'h7f
`define ASRF_RT_LAST 4'hf
`define ASRF_SAMP_A 4'h7
`define ASRF_SAMP_B 4'h8
`define ASRF_SAMP_C 4'h9
`define ASRF_BIT_STOP 4'h9
`define ASRF_TX_LAST 4'h9
`define ASRF_CHAR_RT 8'h9f
`define ASRF_TX_IDLE_CHAR 10'h3ff
`endif

/* File: verilog/asrf_pkg.sv */
// types shared by the serial rate and flag block
// assumes nothing beyond a SystemVerilog compiler
package asrf_pkg;
   typedef enum logic {TX_IDLE, TX_SEND} asrf_tx_state_t;
   typedef enum logic {RX_IDLE, RX_BITS} asrf_rx_state_t;
endpackage : asrf_pkg

/* File: verilog/asrf_flag.sv */
// one sticky status flag: hardware sets, a clearing sequence clears
// assumes set and clear pulses from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module asrf_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic q_o
);
   import asrf_pkg::*;
   typedef struct packed {logic q;} asrf_flag_state_t;
   asrf_flag_state_t s;
   asrf_flag_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////////
   // set beats clear so an event landing on the clear is kept
   always_comb begin
      next_s = s;
      if (set_i) begin
         next_s.q = 1'b1;
      end else if (clr_i) begin
         next_s.q = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s.q <= RST_VAL;
      end else begin
         s <= next_s;
      end
   end

   assign q_o = s.q;

   ////////////////////////////////////////////////////////////////////////////////
   AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      set_i |=> q_o) else $error("flag not set after set pulse");
   AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      (q_o && !clr_i) |=> q_o) else $error("flag dropped without clear");
endmodule : asrf_flag
`default_nettype wire

/* File: verilog/asrf_rate_gen.sv */
// prescaler and binary divider giving the 16x sample tick and the bit tick
// assumes select inputs from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "asrf_regs.svh"
module asrf_rate_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] prescale_i,
   input wire logic [2:0] rate_i,
   input wire logic clr_test_i,
   output logic rt_tick_o,
   output logic bit_tick_o
);
   import asrf_pkg::*;
   typedef struct packed {
      logic [3:0] pre_cnt;
      logic [6:0] bin_cnt;
      logic [3:0] rt_cnt;
   } asrf_rate_state_t;
   asrf_rate_state_t s;
   asrf_rate_state_t next_s;
   logic [3:0] term;
   logic [6:0] mask;
   logic pre_tick;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      unique case (prescale_i)
         2'b00: term = `ASRF_PRE_T0;
         2'b01: term = `ASRF_PRE_T1;
         2'b10: term = `ASRF_PRE_T2;
         2'b11: term = `ASRF_PRE_T3;
      endcase
      // >= so a smaller prescale written mid-count never runs away
      pre_tick = (s.pre_cnt >= term);
      mask = ~(`ASRF_RATE_ALL << rate_i);
      rt_tick_o = pre_tick && ((s.bin_cnt & mask) == mask);
      bit_tick_o = rt_tick_o && (s.rt_cnt == `ASRF_RT_LAST);
      next_s = s;
      if (clr_test_i) begin
         next_s = '0;
      end else begin
         next_s.pre_cnt = pre_tick ? '0 : s.pre_cnt + 4'h1;
         if (pre_tick) begin
            next_s.bin_cnt = s.bin_cnt + 7'h01;
         end
         if (rt_tick_o) begin
            next_s.rt_cnt = s.rt_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_DIV3_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
      (pre_tick && prescale_i == 2'b01 && !clr_test_i) ##1
      (prescale_i == 2'b01 && !clr_test_i && !pre_tick)[*2] ##1
      (prescale_i == 2'b01 && !clr_test_i) |-> pre_tick)
      else $error("divide-by-3 prescale period wrong");
   AST_RATE_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      (rate_i == 3'h0) |-> (rt_tick_o == pre_tick))
      else $error("rate code 0 does not pass prescaler through");
   AST_BIT_SIXTEENTH: assert property (@(posedge clk_i) disable iff (rst_i)
      bit_tick_o |-> (rt_tick_o && s.rt_cnt == `ASRF_RT_LAST))
      else $error("bit tick not on every sixteenth sample tick");
endmodule : asrf_rate_gen
`default_nettype wire

/* File: verilog/asrf_serial_top.sv */
// serial unit: rate registers, transmitter, receiver, status flags, one interrupt
// assumes a classic Wishbone master on clk_i and an asynchronous receive pin
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "asrf_regs.svh"
module asrf_serial_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rxd_i,
   output logic txd_o,
   output logic txd_oe_o,
   output logic irq_o
);
   import asrf_pkg::*;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic irq;
      logic txd;
      logic txd_oe;
      logic [7:0] ctrl;
      logic clr_test;
      logic chk_test;
      logic [1:0] prescale;
      logic [2:0] rate;
      logic [6:0] arm;
      logic [7:0] hold;
      logic hold_full;
      logic preamble;
      asrf_tx_state_t tx_state;
      logic [9:0] tx_shift;
      logic [3:0] tx_cnt;
      logic tx_pin;
      asrf_rx_state_t rx_state;
      logic [3:0] rx_rt;
      logic [3:0] rx_bit;
      logic [1:0] samp;
      logic noise;
      logic [7:0] rx_shift;
      logic [7:0] rx_holding_register;
      logic [7:0] quiet;
      logic busy;
      logic rxd_m;
      logic rxd_s;
   } asrf_top_state_t;
   localparam logic [6:0] FLAG_RST = `ASRF_FLAG_RST;
   asrf_top_state_t s;
   asrf_top_state_t next_s;
   logic [6:0] flags;
   logic [6:0] flag_set;
   logic [6:0] flag_clr;
   logic rt_tick;
   logic bit_tick;
   logic req;
   logic wr;
   logic [5:0] idx;
   logic te;
   logic go;
   logic maj;
   logic noisy;
   logic [2:0] smp;

   ////////////////////////////////////////////////////////////////////////////////
   asrf_rate_gen u_rate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .prescale_i(s.prescale),
      .rate_i(s.rate),
      .clr_test_i(s.clr_test),
      .rt_tick_o(rt_tick),
      .bit_tick_o(bit_tick)
   );

   for (genvar i = 0; i < 7; i++) begin : g_flag
      asrf_flag #(.RST_VAL(FLAG_RST[i])) u_flag (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .set_i(flag_set[i]),
         .clr_i(flag_clr[i]),
         .q_o(flags[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      flag_set = '0;
      flag_clr = '0;
      go = 1'b0;
      smp = {s.samp, s.rxd_s};
      maj = (smp[2] & smp[1]) | (smp[2] & smp[0]) | (smp[1] & smp[0]);
      noisy = !((smp == 3'b000) || (smp == 3'b111));
      te = s.ctrl[`ASRF_C_TE];
      next_s.ack = 1'b0;
      next_s.rxd_m = rxd_i;
      next_s.rxd_s = s.rxd_m;
      req = wb_cyc_i & wb_stb_i & ~s.ack;
      wr = req & wb_we_i & wb_sel_i[0];
      idx = wb_adr_i[7:2];

      // transmitter, paced by the bit tick; reset is the only hard stop
      unique case (s.tx_state)
         TX_IDLE: begin
            if (bit_tick) begin
               if (te && s.preamble) begin
                  next_s.tx_shift = `ASRF_TX_IDLE_CHAR;
                  next_s.preamble = 1'b0;
                  go = 1'b1;
               end else if (te && s.ctrl[`ASRF_C_SBK]) begin
                  next_s.tx_shift = '0;
                  go = 1'b1;
               end else if (te && s.hold_full) begin
                  next_s.tx_shift = {1'b1, s.hold, 1'b0};
                  next_s.hold_full = 1'b0;
                  flag_set[`ASRF_F_TX_HOLDING_EMPTY_FLAG] = 1'b1;
                  go = 1'b1;
               end else if (!te) begin
                  next_s.tx_pin = 1'b0;
               end
            end
            if (go) begin
               next_s.tx_state = TX_SEND;
               next_s.tx_cnt = '0;
            end
         end
         TX_SEND: begin
            if (bit_tick) begin
               if (s.tx_cnt == `ASRF_TX_LAST) begin
                  next_s.tx_state = TX_IDLE;
                  if (!te) begin
                     flag_set = flag_set | `ASRF_TX_MASK;
                  end else if (!s.hold_full && !s.ctrl[`ASRF_C_SBK] && !s.preamble) begin
                     flag_set[`ASRF_F_TC] = 1'b1;
                  end
               end else begin
                  next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                  next_s.tx_cnt = s.tx_cnt + 4'h1;
               end
            end
         end
      endcase

      // receiver on the 16x tick; three middle samples vote
      if (!s.ctrl[`ASRF_C_RE]) begin
         next_s.rx_state = RX_IDLE;
         next_s.busy = 1'b0;
         next_s.quiet = '0;
      end else if (rt_tick) begin
         if (!s.rxd_s) begin
            next_s.quiet = '0;
            next_s.busy = 1'b1;
         end else if (s.quiet != `ASRF_CHAR_RT) begin
            next_s.quiet = s.quiet + 8'h01;
         end else if (s.busy) begin
            next_s.busy = 1'b0;
            flag_set[`ASRF_F_IDLE] = ~s.ctrl[`ASRF_C_RWU];
         end
         unique case (s.rx_state)
            RX_IDLE: begin
               if (!s.rxd_s) begin
                  next_s.rx_state = RX_BITS;
                  next_s.rx_rt = 4'h1;
                  next_s.rx_bit = '0;
                  next_s.noise = 1'b0;
               end
            end
            RX_BITS: begin
               next_s.rx_rt = s.rx_rt + 4'h1;
               if (s.rx_rt == `ASRF_RT_LAST) begin
                  next_s.rx_bit = s.rx_bit + 4'h1;
               end
               if ((s.rx_rt == `ASRF_SAMP_A) || (s.rx_rt == `ASRF_SAMP_B)) begin
                  next_s.samp = {s.samp[0], s.rxd_s};
               end
               if (s.rx_rt == `ASRF_SAMP_C) begin
                  next_s.noise = s.noise | noisy;
                  if (s.rx_bit == '0) begin
                     if (maj) begin
                        next_s.rx_state = RX_IDLE;
                     end
                  end else if (s.rx_bit != `ASRF_BIT_STOP) begin
                     next_s.rx_shift = {maj, s.rx_shift[7:1]};
                  end else begin
                     next_s.rx_state = RX_IDLE;
                     if (flags[`ASRF_F_RX_HOLDING_FULL_FLAG]) begin
                        flag_set[`ASRF_F_OR] = 1'b1;
                     end else begin
                        next_s.rx_holding_register = s.rx_shift;
                        flag_set[`ASRF_F_RX_HOLDING_FULL_FLAG] = 1'b1;
                        flag_set[`ASRF_F_FE] = ~maj;
                        flag_set[`ASRF_F_NF] = s.noise | noisy;
                     end
                  end
               end
            end
         endcase
      end

      // bus slave: one registered answer a clock after the request, unmapped reads zero, writes dropped
      if (req) begin
         next_s.ack = 1'b1;
         next_s.dat = '0;
         case (idx)
            `ASRF_IDX_BAUD: begin
               next_s.dat[7:0] = {s.clr_test, 1'b0, s.prescale, s.chk_test, s.rate};
               if (wr) begin
                  next_s.clr_test = wb_dat_i[`ASRF_BAUD_CLR];
                  next_s.prescale = wb_dat_i[`ASRF_BAUD_PRE+:2];
                  next_s.chk_test = wb_dat_i[`ASRF_BAUD_CHK];
                  next_s.rate = wb_dat_i[2:0];
               end
            end
            `ASRF_IDX_CTRL: begin
               next_s.dat[7:0] = s.ctrl;
               if (wr) begin
                  next_s.ctrl = wb_dat_i[7:0];
                  if (wb_dat_i[`ASRF_C_TE] && !te) begin
                     next_s.preamble = 1'b1;
                     next_s.tx_pin = 1'b1;
                     flag_set = flag_set | `ASRF_TX_MASK;
                  end else if (!wb_dat_i[`ASRF_C_TE] && te) begin
                     next_s.hold_full = 1'b0;
                     next_s.preamble = 1'b0;
                  end
               end
            end
            `ASRF_IDX_STAT: begin
               next_s.dat[7:0] = {flags, 1'b0};
               if (!wb_we_i) begin
                  next_s.arm = s.arm | flags;
               end
            end
            `ASRF_IDX_DATA: begin
               next_s.dat[7:0] = s.rx_holding_register;
               if (wr) begin
                  flag_clr = s.arm & `ASRF_TX_MASK;
                  next_s.arm = s.arm & ~`ASRF_TX_MASK;
                  if (te) begin
                     next_s.hold = wb_dat_i[7:0];
                     next_s.hold_full = 1'b1;
                  end
               end else if (!wb_we_i) begin
                  flag_clr = s.arm & `ASRF_RX_MASK;
                  next_s.arm = s.arm & ~`ASRF_RX_MASK;
               end
            end
            default: begin
            end
         endcase
      end

      // noise and framing never reach the request line
      next_s.irq = (s.ctrl[`ASRF_C_TIE] & flags[`ASRF_F_TX_HOLDING_EMPTY_FLAG])
         | (s.ctrl[`ASRF_C_TX_DONE_IRQ_ENABLE] & flags[`ASRF_F_TC])
         | (s.ctrl[`ASRF_C_RIE] & (flags[`ASRF_F_RX_HOLDING_FULL_FLAG] | flags[`ASRF_F_OR]))
         | (s.ctrl[`ASRF_C_LINE_QUIET_IRQ_ENABLE] & flags[`ASRF_F_IDLE]);
      next_s.txd_oe = next_s.tx_pin;
      next_s.txd = (next_s.tx_state == TX_SEND) ? next_s.tx_shift[0] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.rate <= s.rate;
         s.prescale <= 2'b00;
         s.txd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;
   assign txd_o = s.txd;
   assign txd_oe_o = s.txd_oe;
   assign irq_o = s.irq;

   ////////////////////////////////////////////////////////////////////////////////
   AST_PRESCALE_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (s.prescale == 2'b00))
      else $error("prescale not cleared by reset");
   AST_RATE_KEPT: assert property (@(posedge clk_i)
      ((!rst_i && !(wr && idx == `ASRF_IDX_BAUD)) ##1 rst_i) |=> (s.rate == $past(s.rate, 2)))
      else $error("rate field changed by reset");
   AST_TE_RISE_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ASRF_IDX_CTRL && wb_dat_i[`ASRF_C_TE] && !te)
      |=> (flags[`ASRF_F_TX_HOLDING_EMPTY_FLAG] && flags[`ASRF_F_TC] && s.tx_pin))
      else $error("enable did not set transmitter flags");
   AST_TX_HOLDING_EMPTY_FLAG_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[`ASRF_C_TIE] && flags[`ASRF_F_TX_HOLDING_EMPTY_FLAG]) |=> irq_o)
      else $error("holding-empty interrupt missing");
   AST_TC_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[`ASRF_C_TX_DONE_IRQ_ENABLE] && flags[`ASRF_F_TC]) |=> irq_o)
      else $error("complete interrupt missing");
   AST_RX_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[`ASRF_C_RIE] && (flags[`ASRF_F_RX_HOLDING_FULL_FLAG] || flags[`ASRF_F_OR])) |=> irq_o)
      else $error("receiver interrupt missing");
   AST_IDLE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.ctrl[`ASRF_C_LINE_QUIET_IRQ_ENABLE] && flags[`ASRF_F_IDLE]) |=> irq_o)
      else $error("idle interrupt missing");
   AST_NO_STRAY_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      !((s.ctrl[`ASRF_C_TIE] && flags[`ASRF_F_TX_HOLDING_EMPTY_FLAG]) || (s.ctrl[`ASRF_C_TX_DONE_IRQ_ENABLE] && flags[`ASRF_F_TC])
      || (s.ctrl[`ASRF_C_RIE] && (flags[`ASRF_F_RX_HOLDING_FULL_FLAG] || flags[`ASRF_F_OR]))
      || (s.ctrl[`ASRF_C_LINE_QUIET_IRQ_ENABLE] && flags[`ASRF_F_IDLE])) |=> !irq_o)
      else $error("interrupt without enabled cause");
   AST_OVERRUN_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_set[`ASRF_F_OR] |=> (flags[`ASRF_F_OR] && s.rx_holding_register == $past(s.rx_holding_register)))
      else $error("overrun disturbed held character");
   AST_PIN_ON_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(s.tx_pin) |-> ($past(bit_tick) && !$past(te)))
      else $error("pin released off the bit tick");
   AST_QUEUE_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ASRF_IDX_CTRL && !wb_dat_i[`ASRF_C_TE] && te) |=> !s.hold_full)
      else $error("queued character survived disable");
endmodule : asrf_serial_top
`default_nettype wire

/* File: test/asrf_remote.sv */
// remote station on the serial line: sends frames, decodes what the unit sends
// assumes the bench clock and a bit time given in clocks
`timescale 1ns/1ps
`default_nettype none
module asrf_remote (
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic txd_oe_i,
   input wire logic [15:0] bit_clks_i,
   output logic rxd_o,
   output logic [7:0] last_o,
   output logic [7:0] count_o
);
   logic line;
   logic [7:0] sh;
   // released pin: the pull-up holds the line high
   assign line = txd_oe_i ? txd_i : 1'b1;
   initial begin
      rxd_o = 1'b1;
      last_o = 8'h00;
      count_o = 8'h00;
   end
   ////////////////////////////////////////
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         rxd_o <= f[i];
         repeat (bit_clks_i - 16'h0001) @(posedge clk_i);
      end
      @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask : send
   ////////////////////////////////////////
   // mid-bit sampling; a frame cut by reset still counts, so check before one
   always begin
      @(negedge line);
      repeat (bit_clks_i / 16'h0002) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_clks_i) @(posedge clk_i);
         sh[i] = line;
      end
      repeat (bit_clks_i) @(posedge clk_i);
      last_o = sh;
      count_o = count_o + 8'h01;
   end
endmodule : asrf_remote
`default_nettype wire

/* File: test/async_serial_rate_and_flags_bench.sv */
// bench for the serial rate and flag unit: register calls with expected values
// assumes the remote station model and a single 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module async_serial_rate_and_flags_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, txd, txd_oe, irq, rxd;
   logic [15:0] bit_clks = 16'h0010;
   logic [7:0] last, count, q;
   int failures = 0;
   int n_tests = 0;
   always #4 clk_i = ~clk_i;
   asrf_serial_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd), .txd_oe_o(txd_oe), .irq_o(irq));
   asrf_remote remote (.clk_i(clk_i), .txd_i(txd), .txd_oe_i(txd_oe),
      .bit_clks_i(bit_clks), .rxd_o(rxd), .last_o(last), .count_o(count));
   ////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         failures++;
         $display("[FAIL] %0t no bus acknowledge", $time);
      end
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic wait_start;
      int n;
      n = 0;
      while (!(txd === 1'b0 && txd_oe === 1'b1) && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400) begin
         failures++;
         $display("[FAIL] %0t no start bit on the line", $time);
      end
   endtask : wait_start
   ////////////////////////////////////////
   initial begin
      tick(30000);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      tick(12);
      rst_i <= 1'b0;
      // rate bits stay unknown until first written, so only the reset bits count
      wb(1'b0, 8'hac, 8'h00);
      chk(q & 8'hf8, 8'h00);
      rd(8'hb8, 8'hc0);
      rd(8'h40, 8'h00);
      wb(1'b1, 8'hac, 8'h00);
      // receive: full flag, overrun keeps the old byte, interrupt
      wb(1'b1, 8'hb4, 8'h24);
      remote.send(8'ha5, 1'b1);
      tick(4);
      rd(8'hb8, 8'he0);
      chk({7'h00, irq}, 8'h01);
      remote.send(8'h3c, 1'b1);
      tick(4);
      rd(8'hb8, 8'he8);
      rd(8'hbc, 8'ha5);
      rd(8'hb8, 8'hc0);
      chk({7'h00, irq}, 8'h00);
      tick(170);
      rd(8'hb8, 8'hd0);
      chk({7'h00, irq}, 8'h00);
      wb(1'b1, 8'hb4, 8'h34);
      tick(2);
      chk({7'h00, irq}, 8'h01);
      rd(8'hbc, 8'ha5);
      tick(300);
      rd(8'hb8, 8'hc0);
      // bad stop bit with receiver interrupt off
      wb(1'b1, 8'hb4, 8'h04);
      remote.send(8'h0f, 1'b0);
      tick(4);
      rd(8'hb8, 8'he2);
      chk({7'h00, irq}, 8'h00);
      rd(8'hbc, 8'h0f);
      // rate changed only while the line is quiet: /3 then /2 is 96 clocks a bit
      wb(1'b1, 8'hac, 8'h11);
      bit_clks <= 16'h0060;
      remote.send(8'h96, 1'b1);
      tick(8);
      rd(8'hb8, 8'he0);
      rd(8'hbc, 8'h96);
      wb(1'b1, 8'hb4, 8'h02);
      wb(1'b1, 8'hac, 8'h00);
      bit_clks <= 16'h0010;
      // transmitter flags: clear, then enabling sets them again
      rd(8'hb8, 8'hc0);
      wb(1'b1, 8'hbc, 8'h00);
      rd(8'hb8, 8'h00);
      wb(1'b1, 8'hb4, 8'h0a);
      rd(8'hb8, 8'hc0);
      chk({7'h00, txd_oe}, 8'h01);
      tick(200);
      wb(1'b1, 8'hb4, 8'h02);
      tick(20);
      chk({7'h00, txd_oe}, 8'h00);
      wb(1'b1, 8'hb4, 8'hca);
      tick(2);
      chk({7'h00, irq}, 8'h01);
      rd(8'hb8, 8'hc0);
      wb(1'b1, 8'hbc, 8'h5a);
      rd(8'hb8, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wait_start();
      tick(3);
      chk({7'h00, irq}, 8'h01);
      rd(8'hb8, 8'h80);
      wb(1'b1, 8'hbc, 8'h99);
      // disable with the complete interrupt left on
      wb(1'b1, 8'hb4, 8'h42);
      tick(400);
      rd(8'hb8, 8'hc0);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, txd_oe}, 8'h00);
      chk(count, 8'h01);
      chk(last, 8'h5a);
      // reset in mid-character frees the pin at once
      wb(1'b1, 8'hb4, 8'h0a);
      rd(8'hb8, 8'hc0);
      wb(1'b1, 8'hbc, 8'h33);
      wait_start();
      rst_i <= 1'b1;
      tick(2);
      chk({7'h00, txd_oe}, 8'h00);
      chk({7'h00, txd}, 8'h01);
      rst_i <= 1'b0;
      wb(1'b1, 8'hac, 8'h35);
      rd(8'hac, 8'h35);
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      rd(8'hac, 8'h05);
      report_and_stop();
   end
endmodule : async_serial_rate_and_flags_bench
`default_nettype wire
